// ---- logic/icn_notifier.sv ----
// Input change notifier: per-pin change interrupt, pull controls, sleep wake.
// Assumes pins synchronous to clk while awake; register port answers reads next cycle.
//
// Contract
// - Raise interrupt when a selected, enabled input pin changes state.
// - Detect changes in sleep with clocks stopped, and wake the processor; here a hit reaches wake_req only at a clock edge.
// - Up to 23 monitored inputs numbered from zero, each separately selectable.
// - Six control registers: two irq enable, two pull-up, two pull-down.
// - Each irq enable bit lets its pin's changes produce the interrupt.
// - Each pull-up bit turns on its pin's weak pull-up, independent of pull-down.
// - Each pull-down bit turns on its pin's weak pull-down, independent of pull-up.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "icn_cfg.svh"
module icn_notifier #(
    parameter int NUM_INPUTS = `ICN_NUM_INPUTS
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire icn_pkg::icn_pins_type pins,
    input  wire logic                  sleep_req,
    input  wire icn_pkg::icn_addr_type reg_addr,
    input  wire icn_pkg::icn_word_type reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output icn_pkg::icn_word_type      reg_rdata,
    output icn_pkg::icn_pins_type      pullup_on,
    output icn_pkg::icn_pins_type      pulldown_on,
    output logic                       irq,
    output logic                       wake_req,
    output logic                       sleeping
);
    import icn_pkg::*;

    localparam int HB = `ICN_HIGH_BITS;
    localparam int LB = `ICN_LOW_BITS;

    icn_pins_type irq_en_q;
    icn_pins_type pullup_q;
    icn_pins_type pulldown_q;
    icn_pins_type prev_q;
    icn_pins_type sleep_ref_q;
    logic [`ICN_STAT_WIDTH-1:0] status_q;
    logic [`ICN_STAT_WIDTH-1:0] status_d;
    logic [`ICN_STAT_WIDTH-1:0] int_en_q;
    icn_word_type rdata_q;
    icn_word_type rdata_d;
    logic         irq_q;
    logic         wake_q;
    logic         sleeping_q;
    icn_mode_type mode_q;
    icn_mode_type mode_d;

    // Address decode for the write path; the read mux compares offsets in its own case
    function automatic logic hit(input icn_addr_type a, input icn_addr_type off);
        hit = (a == off);
    endfunction : hit

    wire wr_en_lo  = reg_write & hit(reg_addr, `ICN_OFF_IRQ_EN_LOW);
    wire wr_en_hi  = reg_write & hit(reg_addr, `ICN_OFF_IRQ_EN_HIGH);
    wire wr_pu_lo  = reg_write & hit(reg_addr, `ICN_OFF_PULLUP_LOW);
    wire wr_pu_hi  = reg_write & hit(reg_addr, `ICN_OFF_PULLUP_HIGH);
    wire wr_pd_lo  = reg_write & hit(reg_addr, `ICN_OFF_PULLDOWN_LOW);
    wire wr_pd_hi  = reg_write & hit(reg_addr, `ICN_OFF_PULLDOWN_HIGH);
    wire wr_clear  = reg_write & hit(reg_addr, `ICN_OFF_CLEAR);
    wire wr_int_en = reg_write & hit(reg_addr, `ICN_OFF_INT_ENABLE);

    // Change compare against the previous clocked sample
    icn_pins_type change_vec;
    assign change_vec = (pins ^ prev_q) & irq_en_q;
    wire any_change = |change_vec;

    wire sleep_hit;
    wire in_sleep = (mode_q == ICN_SLEEP);

    icn_sleep_latch #(
        .WIDTH     (NUM_INPUTS)
    ) u_sleep (
        .pins      (pins),
        .enable    (irq_en_q),
        .armed     (in_sleep),
        .ref_level (sleep_ref_q),
        .changed   (sleep_hit)
    );

    // Set wins over a clear arriving in the same cycle
    wire [`ICN_STAT_WIDTH-1:0] set_vec;
    wire [`ICN_STAT_WIDTH-1:0] clr_vec;
    assign set_vec[`ICN_STAT_CHANGE_BIT] = any_change | sleep_hit;
    assign set_vec[`ICN_STAT_WAKE_BIT]   = sleep_hit;
    assign clr_vec = wr_clear ? reg_wdata[`ICN_STAT_WIDTH-1:0] : '0;
    assign status_d = (status_q & ~clr_vec) | set_vec;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ICN_RUN: begin
                if (sleep_req) begin
                    mode_d = ICN_SLEEP;
                end
            end
            ICN_SLEEP: begin
                // The latch holds no request: a hit counts only if the pin still differs at a clock edge
                if (sleep_hit) begin
                    mode_d = ICN_WAKE;
                end else if (!sleep_req) begin
                    mode_d = ICN_RUN;
                end
            end
            ICN_WAKE: begin
                if (!sleep_req) begin
                    mode_d = ICN_RUN;
                end
            end
            default: begin
                mode_d = ICN_RUN;
            end
        endcase
    end

    // Read mux; high registers carry only the upper inputs, rest read zero
    wire [LB-1:0] zero_lo = '0;
    wire [LB-HB-1:0] zero_hi = '0;
    always_comb begin
        rdata_d = `ICN_RESET_VALUE;
        if (reg_read) begin
            case (reg_addr)
                `ICN_OFF_IRQ_EN_LOW:     rdata_d = irq_en_q[LB-1:0];
                `ICN_OFF_IRQ_EN_HIGH:    rdata_d = {zero_hi, irq_en_q[NUM_INPUTS-1:LB]};
                `ICN_OFF_PULLUP_LOW:     rdata_d = pullup_q[LB-1:0];
                `ICN_OFF_PULLUP_HIGH:    rdata_d = {zero_hi, pullup_q[NUM_INPUTS-1:LB]};
                `ICN_OFF_PULLDOWN_LOW:   rdata_d = pulldown_q[LB-1:0];
                `ICN_OFF_PULLDOWN_HIGH:  rdata_d = {zero_hi, pulldown_q[NUM_INPUTS-1:LB]};
                `ICN_OFF_STATUS:         rdata_d = {zero_lo[LB-1:`ICN_STAT_WIDTH], status_q};
                `ICN_OFF_INT_ENABLE:     rdata_d = {zero_lo[LB-1:`ICN_STAT_WIDTH], int_en_q};
                `ICN_OFF_PIN_LEVEL_LOW:  rdata_d = prev_q[LB-1:0];
                `ICN_OFF_PIN_LEVEL_HIGH: rdata_d = {zero_hi, prev_q[NUM_INPUTS-1:LB]};
                default:                 rdata_d = `ICN_RESET_VALUE;
            endcase
        end
    end

    // Six control registers, split low/high word per function
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_bit
            localparam int WB = (gi < LB) ? gi : gi - LB;
            wire sel_en = (gi < LB) ? wr_en_lo : wr_en_hi;
            wire sel_pu = (gi < LB) ? wr_pu_lo : wr_pu_hi;
            wire sel_pd = (gi < LB) ? wr_pd_lo : wr_pd_hi;
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq_en_q[gi]   <= 1'b0;
                    pullup_q[gi]   <= 1'b0;
                    pulldown_q[gi] <= 1'b0;
                end else begin
                    if (sel_en) irq_en_q[gi] <= reg_wdata[WB];
                    if (sel_pu) pullup_q[gi] <= reg_wdata[WB];
                    if (sel_pd) pulldown_q[gi] <= reg_wdata[WB];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q      <= '0;
            sleep_ref_q <= '0;
        end else begin
            prev_q <= pins;
            if (mode_q == ICN_RUN) begin
                sleep_ref_q <= pins;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= '0;
            int_en_q <= '0;
            mode_q   <= ICN_RUN;
            rdata_q  <= `ICN_RESET_VALUE;
        end else begin
            status_q <= status_d;
            mode_q   <= mode_d;
            rdata_q  <= rdata_d;
            if (wr_int_en) begin
                int_en_q <= reg_wdata[`ICN_STAT_WIDTH-1:0];
            end
        end
    end

    // Pulls follow the bits one to one; both-on is left to software
    always_ff @(posedge clk) begin
        if (rst) begin
            pullup_on   <= '0;
            pulldown_on <= '0;
            irq_q       <= 1'b0;
            wake_q      <= 1'b0;
            sleeping_q  <= 1'b0;
        end else begin
            pullup_on   <= pullup_q;
            pulldown_on <= pulldown_q;
            irq_q       <= |(status_d & int_en_q);
            wake_q      <= (mode_d == ICN_WAKE);
            // Same timing as the mode register, but kept as its own flop for the port
            sleeping_q  <= (mode_d == ICN_SLEEP);
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = irq_q;
    assign wake_req  = wake_q;
    assign sleeping  = sleeping_q;
endmodule : icn_notifier

// ---- logic/icn_cfg.svh ----
// Offsets, field positions, reset values and counts of the input change notifier.
// Assumes a 16-bit register port with word offsets in the low address bits.
`ifndef ICN_CFG_SVH
`define ICN_CFG_SVH
`define ICN_NUM_INPUTS         23
`define ICN_ADDR_WIDTH         4
`define ICN_DATA_WIDTH         16
`define ICN_LOW_BITS           16
`define ICN_HIGH_BITS          7
`define ICN_OFF_IRQ_EN_LOW     4'h0
`define ICN_OFF_IRQ_EN_HIGH    4'h1
`define ICN_OFF_PULLUP_LOW     4'h2
`define ICN_OFF_PULLUP_HIGH    4'h3
`define ICN_OFF_PULLDOWN_LOW   4'h4
`define ICN_OFF_PULLDOWN_HIGH  4'h5
`define ICN_OFF_STATUS         4'h6
`define ICN_OFF_CLEAR          4'h7
`define ICN_OFF_INT_ENABLE     4'h8
`define ICN_OFF_PIN_LEVEL_LOW  4'h9
`define ICN_OFF_PIN_LEVEL_HIGH 4'hA
`define ICN_STAT_CHANGE_BIT    0
`define ICN_STAT_WAKE_BIT      1
`define ICN_STAT_WIDTH         2
`define ICN_RESET_VALUE        16'h0000
`endif

// ---- logic/icn_pkg.sv ----
// Types shared by the input change notifier files.
// Assumes icn_cfg.svh is on the include path.
`include "icn_cfg.svh"
package icn_pkg;
    typedef logic [`ICN_NUM_INPUTS-1:0] icn_pins_type;
    typedef logic [`ICN_DATA_WIDTH-1:0] icn_word_type;
    typedef logic [`ICN_ADDR_WIDTH-1:0] icn_addr_type;
    typedef enum logic [1:0] {
        ICN_RUN   = 2'b00,
        ICN_SLEEP = 2'b01,
        ICN_WAKE  = 2'b10
    } icn_mode_type;
endpackage : icn_pkg

// ---- logic/icn_sleep_latch.sv ----
// Clockless catch of a pin change while the system clock is stopped.
// Assumes pins and enables hold still for the time it takes to arm.
`timescale 1ns/1ps
module icn_sleep_latch #(
    parameter int WIDTH = 23
) (
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic             armed,
    input  wire logic [WIDTH-1:0] ref_level,
    output logic                  changed
);
    logic [WIDTH-1:0] diff;
    // A pure level compare holds while the pin differs from the armed
    // reference; the clock domain captures it as a sticky flag on resume.
    assign diff    = (pins ^ ref_level) & enable;
    assign changed = armed & (|diff);
endmodule : icn_sleep_latch

// ---- sim/icn_notifier_properties.sv ----
// Port-level assertions for the input change notifier.
// Assumes it is bound to icn_notifier and sees only its ports.
`timescale 1ns/1ps
`include "icn_cfg.svh"
module icn_props (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire icn_pkg::icn_pins_type pins,
    input wire logic                  sleep_req,
    input wire icn_pkg::icn_addr_type reg_addr,
    input wire icn_pkg::icn_word_type reg_wdata,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire icn_pkg::icn_word_type reg_rdata,
    input wire icn_pkg::icn_pins_type pullup_on,
    input wire icn_pkg::icn_pins_type pulldown_on,
    input wire logic                  irq,
    input wire logic                  wake_req,
    input wire logic                  sleeping
);
    import icn_pkg::*;
    // Shadows of the enables, so outputs can be tied to what software wrote
    icn_pins_type en_q;
    logic [1:0]   ie_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= '0;
            ie_q <= '0;
        end else if (reg_write) begin
            if (reg_addr == `ICN_OFF_IRQ_EN_LOW) en_q[15:0] <= reg_wdata;
            if (reg_addr == `ICN_OFF_IRQ_EN_HIGH) en_q[22:16] <= reg_wdata[6:0];
            if (reg_addr == `ICN_OFF_INT_ENABLE) ie_q <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_pu;
        reg_write && reg_addr == `ICN_OFF_PULLUP_LOW;
    endsequence
    sequence s_wr_pd;
        reg_write && reg_addr == `ICN_OFF_PULLDOWN_HIGH;
    endsequence
    // Awake on both this and the previous cycle, so the previous sample is a real one
    sequence s_change;
        !sleep_req && !$past(sleep_req) && !sleeping && !wake_req && ((pins ^ $past(pins)) & en_q) != '0;
    endsequence
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data outside read answer cycle");
    a_unmapped_zero: assert property (reg_read && reg_addr > `ICN_OFF_PIN_LEVEL_HIGH |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_high_enable_read: assert property (reg_read && reg_addr == `ICN_OFF_IRQ_EN_HIGH
        |=> reg_rdata == 16'($past(en_q[22:16])))
        else $error("high enable readback wrong");
    a_pullup_copy: assert property (s_wr_pu |=> ##1 pullup_on[15:0] == $past(reg_wdata, 2))
        else $error("pull-up output not following register");
    a_pulldown_copy: assert property (s_wr_pd |=> ##1 pulldown_on[22:16] == $past(reg_wdata[6:0], 2))
        else $error("pull-down output not following register");
    a_change_irq: assert property (s_change and ie_q[0] |=> irq)
        else $error("enabled pin change raised no interrupt");
    a_irq_masked: assert property (ie_q == 2'b00 |=> !irq)
        else $error("interrupt high while masked");
    // A hit in the very cycle the request drops still passes through one wake cycle
    a_sleep_exit: assert property (!sleep_req |=> !sleeping && (!wake_req || $past(sleeping)))
        else $error("sleep or wake state without sleep request");
    a_wake_irq: assert property ($rose(wake_req) && ie_q[1] |-> ##[0:1] irq)
        else $error("wake without interrupt");
endmodule : icn_props
bind icn_notifier icn_props icn_props_i (.clk(clk), .rst(rst), .pins(pins), .sleep_req(sleep_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pullup_on(pullup_on), .pulldown_on(pulldown_on), .irq(irq),
    .wake_req(wake_req), .sleeping(sleeping));

// ---- sim/icn_pin_model.sv ----
// Buttons on the monitored pins, with the weak pulls of the notifier.
// Assumes the bench chooses per pin whether a button drives it.
`timescale 1ns/1ps
module icn_pin_model (
    input  wire logic                  clk,
    input  wire icn_pkg::icn_pins_type drive_en,
    input  wire icn_pkg::icn_pins_type drive_level,
    input  wire icn_pkg::icn_pins_type pullup_on,
    input  wire icn_pkg::icn_pins_type pulldown_on,
    output icn_pkg::icn_pins_type      pins
);
    import icn_pkg::*;
    // An unpulled open pin flips each cycle so it never passes for a pull
    icn_pins_type float_q = '0;
    always @(posedge clk) float_q <= ~pins;
    // Only one pull per pin is ever set by the bench
    assign pins = (drive_en & drive_level) | (~drive_en & (pullup_on | (~pulldown_on & float_q)));
endmodule : icn_pin_model

// ---- sim/input_change_notifier_bench.sv ----
// Self-checking bench for the input change notifier.
// Assumes icn_pkg, the design and the pin model are compiled first.
`timescale 1ns/1ps
`include "icn_cfg.svh"
module input_change_notifier_bench;
    import icn_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         sleep_req = 1'b0;
    logic         reg_write = 1'b0;
    logic         reg_read = 1'b0;
    icn_addr_type reg_addr = '0;
    icn_word_type reg_wdata = '0;
    icn_word_type reg_rdata;
    icn_pins_type drv_en = '1;
    icn_pins_type drv_lvl = '0;
    icn_pins_type pins, pullup_on, pulldown_on;
    logic         irq, wake_req, sleeping;
    int           n_fail = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    initial forever #2 clk = ~clk;
    icn_notifier icn_notifier_i (.clk(clk), .rst(rst), .pins(pins), .sleep_req(sleep_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pullup_on(pullup_on), .pulldown_on(pulldown_on), .irq(irq),
        .wake_req(wake_req), .sleeping(sleeping));
    icn_pin_model icn_pin_model_i (.clk(clk), .drive_en(drv_en), .drive_level(drv_lvl),
        .pullup_on(pullup_on), .pulldown_on(pulldown_on), .pins(pins));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input icn_pins_type exp, input icn_pins_type got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // A spare cycle after each write keeps the write-to-read turnaround
    task automatic wr(input icn_addr_type a, input icn_word_type d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input icn_addr_type a, input icn_word_type exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", 23'(exp), 23'(reg_rdata));
        @(posedge clk);
    endtask : rd
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk);
        #1 chk("irq", 23'(exp), 23'(irq));
        @(posedge clk);
    endtask : chk_irq
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++) rd(4'(a), '0);
        wr(`ICN_OFF_PULLUP_LOW, 16'h000F);
        wr(`ICN_OFF_PULLUP_HIGH, 16'h0001);
        wr(`ICN_OFF_PULLDOWN_LOW, 16'h00F0);
        wr(`ICN_OFF_PULLDOWN_HIGH, 16'h0040);
        // Inputs 0 to 7, 16 and 22 left to their pulls only
        drv_en <= 23'h3EFF00;
        @(posedge clk);
        #1 chk("pins", 23'h01000F, pins);
        @(posedge clk);
        drv_lvl <= 23'h00000F;
        drv_en <= '1;
        // Buttons drive every pin again, so the high-word pulls come off
        wr(`ICN_OFF_PULLUP_HIGH, 16'h0000);
        wr(`ICN_OFF_PULLDOWN_HIGH, 16'h0000);
        #1 chk("pullup_on", 23'h00000F, pullup_on);
        chk("pulldown_on", 23'h0000F0, pulldown_on);
        @(posedge clk);
        wr(`ICN_OFF_IRQ_EN_HIGH, 16'hFFFF);
        rd(`ICN_OFF_IRQ_EN_HIGH, 16'h007F);
        wr(`ICN_OFF_INT_ENABLE, 16'h0003);
        wr(`ICN_OFF_IRQ_EN_LOW, 16'h0001);
        drv_lvl <= 23'h00000E;
        chk_irq(1'b1);
        rd(`ICN_OFF_STATUS, 16'h0001);
        wr(`ICN_OFF_CLEAR, 16'h0001);
        drv_lvl <= 23'h00000C;
        chk_irq(1'b0);
        drv_lvl <= 23'h40000C;
        chk_irq(1'b1);
        wr(`ICN_OFF_INT_ENABLE, 16'h0000);
        chk_irq(1'b0);
        wr(`ICN_OFF_INT_ENABLE, 16'h0003);
        wr(`ICN_OFF_CLEAR, 16'h0001);
        chk_irq(1'b0);
        sleep_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("sleeping", 23'h1, 23'(sleeping));
        drv_lvl <= 23'h40000D;
        for (int i = 0; i < 8 && wake_req !== 1'b1; i++) @(posedge clk);
        #1 chk("wake_req", 23'h1, 23'(wake_req));
        chk_irq(1'b1);
        sleep_req <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`ICN_OFF_STATUS, 16'h0003);
        // Reset in mid-run drops the sticky status and the interrupt
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("irq", 23'h0, 23'(irq));
        @(posedge clk);
        rd(`ICN_OFF_STATUS, 16'h0000);
        tally_and_finish();
    end
endmodule : input_change_notifier_bench
